// ==== arcf_top.sv ====
// Register file, result slots and flag logic of the converter compare slice.
// Assumes the converter core pulses conv_done_in once per finished conversion.
`timescale 1ns/10ps
module arcf_top
  import arcf_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr_in,
  input  wire logic              s_axil_awvalid_in,
  output logic                   s_axil_awready_out,
  input  wire logic [DATA_W-1:0] s_axil_wdata_in,
  input  wire logic [STRB_W-1:0] s_axil_wstrb_in,
  input  wire logic              s_axil_wvalid_in,
  output logic                   s_axil_wready_out,
  output logic [1:0]             s_axil_bresp_out,
  output logic                   s_axil_bvalid_out,
  input  wire logic              s_axil_bready_in,
  input  wire logic [ADDR_W-1:0] s_axil_araddr_in,
  input  wire logic              s_axil_arvalid_in,
  output logic                   s_axil_arready_out,
  output logic [DATA_W-1:0]      s_axil_rdata_out,
  output logic [1:0]             s_axil_rresp_out,
  output logic                   s_axil_rvalid_out,
  input  wire logic              s_axil_rready_in,
  input  wire logic              conv_done_in,
  input  wire logic [POS_W-1:0]  conv_pos_in,
  input  wire logic [RES_W-1:0]  conv_result_in,
  output logic                   seq_start_out,
  output logic                   abort_seq_out,
  output logic [NPOS-1:0]        input_buffer_on_out,
  output logic                   cmp_irq_out,
  output logic                   irq_out
);

  logic              wr_en, rd_en, wr_err, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [STRB_W-1:0] wr_strb;
  logic [NPOS-1:0]   wmask;

  arcf_axil_slave arcf_axil_slave_inst (
    .sys_clk_in         (sys_clk_in),
    .srst_in            (srst_in),
    .s_axil_awaddr_in   (s_axil_awaddr_in),
    .s_axil_awvalid_in  (s_axil_awvalid_in),
    .s_axil_awready_out (s_axil_awready_out),
    .s_axil_wdata_in    (s_axil_wdata_in),
    .s_axil_wstrb_in    (s_axil_wstrb_in),
    .s_axil_wvalid_in   (s_axil_wvalid_in),
    .s_axil_wready_out  (s_axil_wready_out),
    .s_axil_bresp_out   (s_axil_bresp_out),
    .s_axil_bvalid_out  (s_axil_bvalid_out),
    .s_axil_bready_in   (s_axil_bready_in),
    .s_axil_araddr_in   (s_axil_araddr_in),
    .s_axil_arvalid_in  (s_axil_arvalid_in),
    .s_axil_arready_out (s_axil_arready_out),
    .s_axil_rdata_out   (s_axil_rdata_out),
    .s_axil_rresp_out   (s_axil_rresp_out),
    .s_axil_rvalid_out  (s_axil_rvalid_out),
    .s_axil_rready_in   (s_axil_rready_in),
    .wr_en_out          (wr_en),
    .wr_addr_out        (wr_addr),
    .wr_data_out        (wr_data),
    .wr_strb_out        (wr_strb),
    .wr_err_in          (wr_err),
    .rd_en_out          (rd_en),
    .rd_addr_out        (rd_addr),
    .rd_data_in         (rd_data),
    .rd_err_in          (rd_err)
  );

  // Registers are twelve bits wide in the low two byte lanes
  assign wmask = {{(NPOS-8){wr_strb[1]}}, {8{wr_strb[0]}}};

  // Address decode
  logic              wr_slot_ok, rd_slot_ok;
  logic [ADDR_W-1:0] wr_slot_off, rd_slot_off;
  logic [POS_W-1:0]  wr_slot_pos, rd_slot_pos;
  logic              wr_ctrl, wr_ovr, wr_seq, wr_compare_enable_bit, wr_flags, wr_dien, wr_higher_than_operator;
  logic              wr_irq_en, wr_irq_clr;

  assign wr_slot_off = wr_addr - ADDR_SLOT0;
  assign rd_slot_off = rd_addr - ADDR_SLOT0;
  assign wr_slot_pos = wr_slot_off[SLOT_SHIFT +: POS_W];
  assign rd_slot_pos = rd_slot_off[SLOT_SHIFT +: POS_W];
  assign wr_slot_ok  = (wr_addr >= ADDR_SLOT0) && (wr_addr <= ADDR_SLOT_LAST)
                       && (wr_slot_off[SLOT_SHIFT-1:0] == SLOT_ALIGN);
  assign rd_slot_ok  = (rd_addr >= ADDR_SLOT0) && (rd_addr <= ADDR_SLOT_LAST)
                       && (rd_slot_off[SLOT_SHIFT-1:0] == SLOT_ALIGN);

  assign wr_ctrl    = wr_en && (wr_addr == ADDR_CTRL);
  assign wr_ovr     = wr_en && (wr_addr == ADDR_OVR);
  assign wr_seq     = wr_en && (wr_addr == ADDR_SEQ);
  assign wr_compare_enable_bit    = wr_en && (wr_addr == ADDR_COMPARE_ENABLE_BIT);
  assign wr_flags   = wr_en && (wr_addr == ADDR_FLAGS);
  assign wr_dien    = wr_en && (wr_addr == ADDR_DIEN);
  assign wr_higher_than_operator   = wr_en && (wr_addr == ADDR_HIGHER_THAN_OPERATOR);
  assign wr_irq_en  = wr_en && (wr_addr == ADDR_IRQ_EN);
  assign wr_irq_clr = wr_en && (wr_addr == ADDR_IRQ_CLR);
  assign wr_err     = !(wr_slot_ok || (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_OVR)
                        || (wr_addr == ADDR_SEQ) || (wr_addr == ADDR_COMPARE_ENABLE_BIT)
                        || (wr_addr == ADDR_FLAGS) || (wr_addr == ADDR_DIEN)
                        || (wr_addr == ADDR_HIGHER_THAN_OPERATOR) || (wr_addr == ADDR_IRQ_STAT)
                        || (wr_addr == ADDR_IRQ_EN) || (wr_addr == ADDR_IRQ_CLR));

  // Software state
  logic              fast_flag_clear, next_fast_flag_clear, irqen, next_irqen;
  logic [NPOS-1:0]   compare_enable_bit, next_compare_enable_bit, higher_than_operator, next_higher_than_operator, dien, next_dien;
  logic [NIRQ-1:0]   irq_mask, next_irq_mask;
  logic              seq_start, next_seq_start, abort_seq, next_abort_seq;

  always_comb begin
    next_fast_flag_clear      = fast_flag_clear;
    next_irqen     = irqen;
    next_compare_enable_bit      = compare_enable_bit;
    next_higher_than_operator     = higher_than_operator;
    next_dien      = dien;
    next_irq_mask  = irq_mask;
    next_seq_start = wr_seq;
    next_abort_seq = wr_compare_enable_bit || wr_higher_than_operator;
    if (wr_ctrl && wr_strb[0]) begin
      next_fast_flag_clear  = wr_data[CTRL_FAST_FLAG_CLEAR_BIT];
      next_irqen = wr_data[CTRL_IRQEN_BIT];
    end
    if (wr_compare_enable_bit) begin
      next_compare_enable_bit = (compare_enable_bit & ~wmask) | (wr_data[NPOS-1:0] & wmask);
    end
    if (wr_higher_than_operator) begin
      next_higher_than_operator = (higher_than_operator & ~wmask) | (wr_data[NPOS-1:0] & wmask);
    end
    if (wr_dien) begin
      next_dien = (dien & ~wmask) | (wr_data[NPOS-1:0] & wmask);
    end
    if (wr_irq_en && wr_strb[0]) begin
      next_irq_mask = wr_data[NIRQ-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fast_flag_clear      <= 1'b0;
      irqen     <= 1'b0;
      compare_enable_bit      <= RST_POS;
      higher_than_operator     <= RST_POS;
      dien      <= RST_POS;
      irq_mask  <= RST_IRQ;
      seq_start <= 1'b0;
      abort_seq <= 1'b0;
    end else begin
      fast_flag_clear      <= next_fast_flag_clear;
      irqen     <= next_irqen;
      compare_enable_bit      <= next_compare_enable_bit;
      higher_than_operator     <= next_higher_than_operator;
      dien      <= next_dien;
      irq_mask  <= next_irq_mask;
      seq_start <= next_seq_start;
      abort_seq <= next_abort_seq;
    end
  end

  // Slots and flags, one lane per sequence position
  logic [RES_W-1:0] slot [NPOS];
  logic [NPOS-1:0]  flags, flag_set, ovr_hit;

  for (genvar n = 0; n < NPOS; n++) begin : g_pos
    localparam logic [POS_W-1:0] POS = POS_W'(n);
    logic             conv_here, store_res, sw_wr, sw_rd, soft_clr;
    logic [RES_W-1:0] next_slot;

    assign conv_here = conv_done_in && (conv_pos_in == POS);
    assign store_res = conv_here && !compare_enable_bit[n];
    assign sw_wr     = wr_en && wr_slot_ok && (wr_slot_pos == POS);
    assign sw_rd     = rd_en && rd_slot_ok && (rd_slot_pos == POS);
    assign soft_clr  = (!fast_flag_clear && wr_flags && wmask[n] && wr_data[n])
                       || (fast_flag_clear && !compare_enable_bit[n] && sw_rd)
                       || (fast_flag_clear && compare_enable_bit[n] && sw_wr);
    assign ovr_hit[n] = store_res && flags[n];

    // Converter result beats a software write in the same cycle
    always_comb begin
      next_slot = slot[n];
      if (store_res) begin
        next_slot = conv_result_in;
      end else if (sw_wr) begin
        next_slot = (slot[n] & ~wmask) | (wr_data[RES_W-1:0] & wmask);
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
        slot[n] <= RST_SLOT;
      end else begin
        slot[n] <= next_slot;
      end
    end

    arcf_flag_cell arcf_flag_cell_inst (
      .sys_clk_in     (sys_clk_in),
      .srst_in        (srst_in),
      .conv_here_in   (conv_here),
      .result_in      (conv_result_in),
      .compare_in     (slot[n]),
      .cmp_en_in      (compare_enable_bit[n]),
      .higher_than_in (higher_than_operator[n]),
      .start_clr_in   (wr_seq),
      .soft_clr_in    (soft_clr),
      .flag_out       (flags[n]),
      .set_out        (flag_set[n])
    );
  end

  // Overrun and interrupt status; hardware set wins over software clear, but a sequence start or compare setup write clears overrun over a set
  logic            ovr, next_ovr;
  logic [NIRQ-1:0] irq_stat, next_irq_stat, irq_ev;

  assign irq_ev[IRQ_CMP_BIT] = |(flag_set & compare_enable_bit);
  assign irq_ev[IRQ_OVR_BIT] = |ovr_hit;

  always_comb begin
    next_ovr = ovr;
    if (wr_seq || wr_compare_enable_bit || wr_higher_than_operator) begin
      next_ovr = 1'b0;
    end else if (|ovr_hit) begin
      next_ovr = 1'b1;
    end else if (wr_ovr && wr_strb[0] && wr_data[OVR_BIT]) begin
      next_ovr = 1'b0;
    end
    next_irq_stat = irq_stat;
    if (wr_irq_clr && wr_strb[0]) begin
      next_irq_stat = irq_stat & ~wr_data[NIRQ-1:0];
    end
    next_irq_stat = next_irq_stat | irq_ev;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ovr      <= 1'b0;
      irq_stat <= RST_IRQ;
    end else begin
      ovr      <= next_ovr;
      irq_stat <= next_irq_stat;
    end
  end

  // Read mux; write-only clear register reads as zero
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (rd_slot_ok) begin
      rd_data = DATA_W'(slot[rd_slot_pos]);
    end else begin
      case (rd_addr)
        ADDR_CTRL: begin
          rd_data[CTRL_FAST_FLAG_CLEAR_BIT]  = fast_flag_clear;
          rd_data[CTRL_IRQEN_BIT] = irqen;
        end
        ADDR_OVR:      rd_data[OVR_BIT] = ovr;
        ADDR_SEQ:      rd_data = '0;
        ADDR_COMPARE_ENABLE_BIT:     rd_data = DATA_W'(compare_enable_bit);
        ADDR_FLAGS:    rd_data = DATA_W'(flags);
        ADDR_DIEN:     rd_data = DATA_W'(dien);
        ADDR_HIGHER_THAN_OPERATOR:    rd_data = DATA_W'(higher_than_operator);
        ADDR_IRQ_STAT: rd_data = DATA_W'(irq_stat);
        ADDR_IRQ_EN:   rd_data = DATA_W'(irq_mask);
        ADDR_IRQ_CLR:  rd_data = '0;
        default:       rd_err  = 1'b1;
      endcase
    end
  end

  assign seq_start_out       = seq_start;
  assign abort_seq_out       = abort_seq;
  assign input_buffer_on_out = dien;
  assign cmp_irq_out         = irqen && |(flags & compare_enable_bit);
  assign irq_out             = |(irq_stat & irq_mask);

endmodule : arcf_top

// ==== arcf_pkg.sv ====
// Package for the converter result compare and flag slice.
// Assumes register indices are word indices: byte address is four times the index.
package arcf_pkg;

  localparam int NPOS   = 12;
  localparam int RES_W  = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int POS_W  = 4;

  // Word indices of the register map
  localparam logic [ADDR_W-1:0] IDX_CTRL      = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_OVR       = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_SEQ       = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_COMPARE_ENABLE_BIT      = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_FLAGS     = 8'h0A;
  localparam logic [ADDR_W-1:0] IDX_DIEN      = 8'h0C;
  localparam logic [ADDR_W-1:0] IDX_HIGHER_THAN_OPERATOR     = 8'h0E;
  localparam logic [ADDR_W-1:0] IDX_SLOT0     = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_SLOT_LAST = 8'h26;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT  = 8'h30;
  localparam logic [ADDR_W-1:0] IDX_IRQ_EN    = 8'h31;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLR   = 8'h32;

  function automatic logic [ADDR_W-1:0] arcf_byte_addr(input logic [ADDR_W-1:0] idx);
    return {idx[ADDR_W-3:0], 2'h0};
  endfunction : arcf_byte_addr

  localparam logic [ADDR_W-1:0] ADDR_CTRL      = arcf_byte_addr(IDX_CTRL);
  localparam logic [ADDR_W-1:0] ADDR_OVR       = arcf_byte_addr(IDX_OVR);
  localparam logic [ADDR_W-1:0] ADDR_SEQ       = arcf_byte_addr(IDX_SEQ);
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_ENABLE_BIT      = arcf_byte_addr(IDX_COMPARE_ENABLE_BIT);
  localparam logic [ADDR_W-1:0] ADDR_FLAGS     = arcf_byte_addr(IDX_FLAGS);
  localparam logic [ADDR_W-1:0] ADDR_DIEN      = arcf_byte_addr(IDX_DIEN);
  localparam logic [ADDR_W-1:0] ADDR_HIGHER_THAN_OPERATOR     = arcf_byte_addr(IDX_HIGHER_THAN_OPERATOR);
  localparam logic [ADDR_W-1:0] ADDR_SLOT0     = arcf_byte_addr(IDX_SLOT0);
  localparam logic [ADDR_W-1:0] ADDR_SLOT_LAST = arcf_byte_addr(IDX_SLOT_LAST);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = arcf_byte_addr(IDX_IRQ_STAT);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = arcf_byte_addr(IDX_IRQ_EN);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR   = arcf_byte_addr(IDX_IRQ_CLR);

  // Slots sit two indices apart, so eight bytes apart
  localparam int                SLOT_SHIFT     = 3;
  localparam logic [2:0]        SLOT_ALIGN     = 3'h0;

  // Field positions
  localparam int CTRL_FAST_FLAG_CLEAR_BIT  = 0;
  localparam int CTRL_IRQEN_BIT = 1;
  localparam int OVR_BIT        = 0;
  localparam int IRQ_CMP_BIT    = 0;
  localparam int IRQ_OVR_BIT    = 1;
  localparam int NIRQ           = 2;

  // Reset values
  localparam logic [NPOS-1:0]  RST_POS  = 12'h000;
  localparam logic [RES_W-1:0] RST_SLOT = 12'h000;
  localparam logic [NIRQ-1:0]  RST_IRQ  = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ARCF_RD_IDLE = 2'h0,
    ARCF_RD_DATA = 2'h1
  } arcf_rd_state_e;

endpackage : arcf_pkg

// ==== arcf_axil_slave.sv ====
// AXI4-Lite slave front end: turns bus transfers into one-cycle access strobes.
// Assumes the register file answers read data and decode errors combinationally.
`timescale 1ns/10ps
module arcf_axil_slave
  import arcf_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr_in,
  input  wire logic              s_axil_awvalid_in,
  output logic                   s_axil_awready_out,
  input  wire logic [DATA_W-1:0] s_axil_wdata_in,
  input  wire logic [STRB_W-1:0] s_axil_wstrb_in,
  input  wire logic              s_axil_wvalid_in,
  output logic                   s_axil_wready_out,
  output logic [1:0]             s_axil_bresp_out,
  output logic                   s_axil_bvalid_out,
  input  wire logic              s_axil_bready_in,
  input  wire logic [ADDR_W-1:0] s_axil_araddr_in,
  input  wire logic              s_axil_arvalid_in,
  output logic                   s_axil_arready_out,
  output logic [DATA_W-1:0]      s_axil_rdata_out,
  output logic [1:0]             s_axil_rresp_out,
  output logic                   s_axil_rvalid_out,
  input  wire logic              s_axil_rready_in,
  output logic                   wr_en_out,
  output logic [ADDR_W-1:0]      wr_addr_out,
  output logic [DATA_W-1:0]      wr_data_out,
  output logic [STRB_W-1:0]      wr_strb_out,
  input  wire logic              wr_err_in,
  output logic                   rd_en_out,
  output logic [ADDR_W-1:0]      rd_addr_out,
  input  wire logic [DATA_W-1:0] rd_data_in,
  input  wire logic              rd_err_in
);

  logic                aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0]   awaddr, next_awaddr;
  logic [DATA_W-1:0]   wdata, next_wdata, rdata, next_rdata;
  logic [STRB_W-1:0]   wstrb, next_wstrb;
  logic                bvalid, next_bvalid;
  logic [1:0]          bresp, next_bresp, rresp, next_rresp;
  arcf_rd_state_e      rd_state, next_rd_state;

  // No new address or data while a response waits: one write at a time
  assign s_axil_awready_out = !aw_held && !bvalid;
  assign s_axil_wready_out  = !w_held && !bvalid;
  assign s_axil_bvalid_out  = bvalid;
  assign s_axil_bresp_out   = bresp;
  assign wr_en_out          = aw_held && w_held && !bvalid;
  assign wr_addr_out        = awaddr;
  assign wr_data_out        = wdata;
  assign wr_strb_out        = wstrb;

  assign s_axil_arready_out = (rd_state == ARCF_RD_IDLE);
  assign rd_en_out          = s_axil_arvalid_in && (rd_state == ARCF_RD_IDLE);
  assign rd_addr_out        = s_axil_araddr_in;
  assign s_axil_rvalid_out  = (rd_state == ARCF_RD_DATA);
  assign s_axil_rdata_out   = rdata;
  assign s_axil_rresp_out   = rresp;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_awaddr  = awaddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axil_awvalid_in && s_axil_awready_out) begin
      next_aw_held = 1'b1;
      next_awaddr  = s_axil_awaddr_in;
    end
    if (s_axil_wvalid_in && s_axil_wready_out) begin
      next_w_held = 1'b1;
      next_wdata  = s_axil_wdata_in;
      next_wstrb  = s_axil_wstrb_in;
    end
    if (wr_en_out) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_err_in ? RESP_SLVERR : RESP_OKAY;
    end
    if (bvalid && s_axil_bready_in) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      ARCF_RD_IDLE: begin
        if (rd_en_out) begin
          next_rd_state = ARCF_RD_DATA;
          next_rdata    = rd_data_in;
          next_rresp    = rd_err_in ? RESP_SLVERR : RESP_OKAY;
        end
      end
      ARCF_RD_DATA: begin
        if (s_axil_rready_in) begin
          next_rd_state = ARCF_RD_IDLE;
        end
      end
      default: next_rd_state = ARCF_RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr   <= '0;
      wdata    <= '0;
      wstrb    <= '0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      rd_state <= ARCF_RD_IDLE;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      awaddr   <= next_awaddr;
      wdata    <= next_wdata;
      wstrb    <= next_wstrb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

endmodule : arcf_axil_slave

// ==== arcf_flag_cell.sv ====
// One conversion-complete flag with its compare test and clear priorities.
// Assumes all clear strobes are one-cycle pulses from the register file.
`timescale 1ns/10ps
module arcf_flag_cell
  import arcf_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic             conv_here_in,
  input  wire logic [RES_W-1:0] result_in,
  input  wire logic [RES_W-1:0] compare_in,
  input  wire logic             cmp_en_in,
  input  wire logic             higher_than_in,
  input  wire logic             start_clr_in,
  input  wire logic             soft_clr_in,
  output logic                  flag_out,
  output logic                  set_out
);

  logic flag, next_flag;
  logic test_true;

  // Full twelve bits always, whatever the resolution
  assign test_true = higher_than_in ? (result_in > compare_in)
                                    : (result_in <= compare_in);
  assign set_out   = conv_here_in && (!cmp_en_in || test_true);
  assign flag_out  = flag;

  always_comb begin
    next_flag = flag;
    if (start_clr_in) begin
      next_flag = 1'b0;
    end else if (set_out) begin
      next_flag = 1'b1;
    end else if (soft_clr_in) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : arcf_flag_cell

// ==== arcf_sva.sv ====
// Checker: bus answer and irq relations of the compare slice.
// Assumes it is bound onto arcf_top and sees only its ports.
`timescale 1ns/10ps
module arcf_sva
  import arcf_pkg::*;
(
  input wire logic            sys_clk_in,
  input wire logic            srst_in,
  input wire logic            s_axil_bvalid_out,
  input wire logic            s_axil_arvalid_in,
  input wire logic            s_axil_arready_out,
  input wire logic            s_axil_rvalid_out,
  input wire logic            conv_done_in,
  input wire logic            seq_start_out,
  input wire logic            abort_seq_out,
  input wire logic [NPOS-1:0] input_buffer_on_out,
  input wire logic            cmp_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_rd_answer: assert property (s_axil_arvalid_in && s_axil_arready_out |=> s_axil_rvalid_out)
    else $error("read answer late");
  a_abort_pulse: assert property (abort_seq_out |=> !abort_seq_out)
    else $error("abort pulse too long");
  a_abort_cause: assert property ($rose(abort_seq_out) |-> ##[0:1] s_axil_bvalid_out)
    else $error("abort without write");
  a_start_pulse: assert property (seq_start_out |=> !seq_start_out)
    else $error("start pulse too long");
  a_start_clear: assert property (seq_start_out |-> !cmp_irq_out)
    else $error("flags survive start");
  a_irq_rise: assert property ($rose(cmp_irq_out) |-> $past(conv_done_in)
    or ##[0:1] s_axil_bvalid_out) else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(cmp_irq_out)
    |-> $past(s_axil_arvalid_in && s_axil_arready_out) or ##[0:1] s_axil_bvalid_out)
    else $error("irq fell without clear");
  a_buf_steady: assert property ($changed(input_buffer_on_out)
    |-> ##[0:1] s_axil_bvalid_out) else $error("buffer enable moved alone");
endmodule : arcf_sva

bind arcf_top arcf_sva arcf_sva_inst (.*);

// ==== arcf_top_tb_top.sv ====
// Testbench: random compare runs and clear cases over AXI4-Lite.
// Assumes a 20 MHz clock and synchronous active-high reset.
`timescale 1ns/10ps
module arcf_top_tb_top
  import arcf_pkg::*;
;
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic cd = 1'h0, awr, wrd, bv, arr, rv, ci, iq;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, v, seed = 32'h00000B5B;
  logic [3:0] ws = '0, cp = '0;
  logic [11:0] cr = '0, r, op, ef, ib, cv [12];
  logic [1:0] bresp, rresp, rres;
  int mismatches = 0, samples_checked = 0, i;
  arcf_top arcf_top_inst (.sys_clk_in(clk), .srst_in(rst), .s_axil_awaddr_in(awa),
    .s_axil_awvalid_in(awv), .s_axil_awready_out(awr), .s_axil_wdata_in(wd),
    .s_axil_wstrb_in(ws), .s_axil_wvalid_in(wv), .s_axil_wready_out(wrd),
    .s_axil_bresp_out(bresp), .s_axil_bvalid_out(bv), .s_axil_bready_in(br),
    .s_axil_araddr_in(ara), .s_axil_arvalid_in(arv), .s_axil_arready_out(arr),
    .s_axil_rdata_out(rdat), .s_axil_rresp_out(rresp), .s_axil_rvalid_out(rv),
    .s_axil_rready_in(rr), .conv_done_in(cd), .conv_pos_in(cp), .conv_result_in(cr),
    .seq_start_out(), .abort_seq_out(), .input_buffer_on_out(ib), .cmp_irq_out(ci),
    .irq_out(iq));
  always #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic hit(input logic o, input logic [11:0] a, input logic [11:0] c);
    return o ? (a > c) : (a <= c);
  endfunction : hit
  function automatic logic [7:0] slot(input int n);
    return ADDR_SLOT0 + 8'(n << SLOT_SHIFT);
  endfunction : slot
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int n;
    logic ha, hw, hb;
    logic [1:0] q;
    @(posedge clk);
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    hb = 1'h0; n = 0;
    while (!hb && n < 50) begin
      @(negedge clk); ha = awv && awr; hw = wv && wrd; hb = bv; q = bresp; n++;
      @(posedge clk); if (ha) awv <= 1'h0; if (hw) wv <= 1'h0;
    end
    br <= 1'h0;
    chk("bvalid", 1, 32'(hb));
    chk("bresp", 32'(e), 32'(q));
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    int n;
    logic h, hr;
    @(posedge clk);
    ara <= a; arv <= 1'h1; rr <= 1'h1; hr = 1'h0; n = 0;
    while (!hr && n < 50) begin
      @(negedge clk); h = arv && arr; hr = rv; v = rdat; rres = rresp; n++;
      @(posedge clk); if (h) arv <= 1'h0;
    end
    rr <= 1'h0;
    chk("rvalid", 1, 32'(hr));
    chk(nm, e, v);
  endtask : rc
  task automatic conv(input int p, input logic [11:0] d);
    @(posedge clk); cd <= 1'h1; cp <= 4'(p); cr <= d;
    @(posedge clk); cd <= 1'h0; cr <= ~d;
  endtask : conv
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rc(ADDR_COMPARE_ENABLE_BIT, 0, "compare_enable_bit"); rc(ADDR_HIGHER_THAN_OPERATOR, 0, "higher_than_operator"); rc(ADDR_FLAGS, 0, "flags");
    wr(8'hFC, 1, RESP_SLVERR); rc(8'hFC, 0, "unmapped"); chk("rresp", 2, rres);
    op = 12'(rnd()); wr(ADDR_DIEN, op); rc(ADDR_DIEN, op, "dien");
    @(negedge clk); chk("ibuf", 32'(op), 32'(ib));
    // Bit 5 forced to lower-or-same: its equal result is the boundary case
    op = 12'(rnd()) & 12'hFDF;
    for (i = 0; i < 12; i++) begin cv[i] = 12'(rnd()); wr(slot(i), 32'(cv[i])); end
    wr(ADDR_COMPARE_ENABLE_BIT, 32'hFFF); wr(ADDR_HIGHER_THAN_OPERATOR, 32'(op)); wr(ADDR_CTRL, 2); wr(ADDR_IRQ_EN, 1);
    wr(ADDR_SEQ, 0);
    for (i = 0; i < 12; i++) begin
      r = (i == 5) ? cv[5] : 12'(rnd()); conv(i, r); ef[i] = hit(op[i], r, cv[i]);
    end
    rc(ADDR_FLAGS, 32'(ef), "flags");
    @(negedge clk); chk("cmpirq", 1, 32'(ci)); chk("irq", 1, 32'(iq));
    for (i = 0; i < 12; i++) rc(slot(i), 32'(cv[i]), "slot");
    rc(ADDR_IRQ_STAT, 1, "irqstat"); wr(ADDR_IRQ_CLR, 1);
    @(negedge clk); chk("irq", 0, 32'(iq));
    wr(ADDR_SEQ, 0); rc(ADDR_FLAGS, 0, "flags");
    @(negedge clk); chk("cmpirq", 0, 32'(ci));
    wr(ADDR_COMPARE_ENABLE_BIT, 0); r = 12'(rnd()); conv(4, r); conv(4, r);
    rc(slot(4), 32'(r), "slot"); rc(ADDR_OVR, 1, "ovr");
    rc(ADDR_IRQ_STAT, 2, "irqstat");
    rc(ADDR_FLAGS, 32'h10, "flags"); wr(ADDR_FLAGS, 32'h10); rc(ADDR_FLAGS, 0, "flags");
    wr(ADDR_CTRL, 1); conv(3, r); rc(slot(3), 32'(r), "slot"); rc(ADDR_FLAGS, 0, "flags");
    wr(ADDR_COMPARE_ENABLE_BIT, 4); wr(ADDR_HIGHER_THAN_OPERATOR, 0); wr(slot(2), 32'hFFF); conv(2, r);
    rc(ADDR_FLAGS, 4, "flags"); wr(slot(2), 32'hFFF); rc(ADDR_FLAGS, 0, "flags");
    wr(ADDR_CTRL, 2); r = 12'(rnd());
    // Clear and set on one edge: the internal write lands one cycle after the handshake
    fork wr(ADDR_FLAGS, 32'h40); begin @(posedge clk); conv(6, r); end join
    rc(ADDR_FLAGS, 32'h40, "flags");
    fork wr(ADDR_SEQ, 0); begin @(posedge clk); conv(6, r); end join
    rc(ADDR_FLAGS, 0, "flags");
    end_sim();
  end
  initial begin
    #(50 * 6000);
    mismatches++;
    end_sim();
  end
endmodule : arcf_top_tb_top
